// [hdl/sfw_pkg.sv]
package sfw_pkg;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_WRAP = 8'h77;
  localparam logic [7:0] OP_PAGE_CLR = 8'h81;
  localparam logic [7:0] OP_SMALL_CLR = 8'h20;
  localparam logic [7:0] OP_HALF_CLR = 8'h52;
  localparam logic [7:0] OP_REGION_CLR = 8'hD8;
  localparam logic [7:0] OP_ALL_CLR_A = 8'h60;
  localparam logic [7:0] OP_ALL_CLR_B = 8'hC7;
  localparam logic [7:0] OP_PAGE_WR = 8'h02;
  // ----------------------------------------
  // Frame lengths in whole bytes
  // ----------------------------------------
  localparam logic [2:0] NB_OP = 3'h1;
  localparam logic [2:0] NB_ADDR = 3'h4;
  localparam logic [2:0] NB_WRAP = 3'h5;
  localparam logic [2:0] NB_DATA = 3'h5;
  localparam logic [2:0] NB_SAT = 3'h6;
  // ----------------------------------------
  // Wrap field: {len[1:0], disable}
  // ----------------------------------------
  localparam logic [2:0] WRAP_RST = 3'h1;
  localparam int WRAP_LSB = 4;
  // ----------------------------------------
  // Erase region masks and block index
  // ----------------------------------------
  localparam logic [23:0] MSK_PAGE = 24'hFFFF00;
  localparam logic [23:0] MSK_SECT = 24'hFFF000;
  localparam logic [23:0] MSK_HALF = 24'hFF8000;
  localparam logic [23:0] MSK_BLK = 24'hFF0000;
  localparam logic [23:0] MSK_CHIP = 24'h000000;
  localparam int BLK_LSB = 16;
  localparam logic [6:0] NUM_BLK = 7'h20;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int T_PROG_US = 8;
  localparam int T_ERASE_US = 40;
  localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
  localparam int ERASE_CYC = T_ERASE_US * CLK_MHZ;
  localparam int PAGE_BYTES = 256;

  typedef enum logic [2:0] {
    K_PAGE, K_SECT, K_HALF, K_BLK, K_CHIP, K_PROG
  } sfw_kind_e;
  typedef enum logic [1:0] {S_IDLE, S_WALK, S_TIME} sfw_state_e;
endpackage

// [hdl/sfw_core.sv]
// What this block does
// - Wrap setup is opcode, 24 dummy bits, wrap byte; latch wrap field.
// - Wrap setting applies to all later quad reads inside a page.
// - Disable bit 0 enables wrap; upper bits pick 8/16/32/64; default off.
// - Erase and program need write latch flag, set by write enable.
// - Page clear: opcode plus three address bytes, whole page to ones.
// - Sector clear: opcode plus three address bytes, whole sector.
// - Half block clear: opcode plus three address bytes, whole half.
// - Block clear: opcode plus three address bytes, whole block.
// - Address erases run only if select rises right after fourth byte.
// - Chip clear is opcode alone, two opcodes, select after eighth bit.
// - Chip clear runs only when all protect bits are zero.
// - No erase or program on a protected area.
// - Valid command starts timed cycle; busy flag; latch cleared early.
// - Page write: opcode, address, data bytes programmed from address.
// - Page write data wraps to page start, never crosses pages.
// - Over 256 bytes: only the last 256 are programmed.
// - Under 256 bytes: other bytes of the page stay unchanged.
// - Page write runs only if select rises on a byte boundary.
`timescale 1ns/1ps
module sfw_core #(
  parameter int ERASE_CYC = sfw_pkg::ERASE_CYC,
  parameter int PROG_CYC = sfw_pkg::PROG_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic si,
  input wire logic [4:0] protect_range_bits,
  output logic write_latch_flag,
  output logic op_active_flag,
  output logic wrap_active,
  output logic [1:0] wrap_len_sel,
  output logic arr_erase,
  output sfw_pkg::sfw_kind_e arr_kind,
  output logic [23:0] arr_addr,
  output logic arr_we,
  output logic [7:0] arr_wdata,
  output logic cmd_reject
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rs1_q, rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // ----------------------------------------
  // Serial clock side
  // ----------------------------------------
  logic first_q, tog_q, bsy1_q, bsy2_q;
  logic [2:0] bit_q, nb_q;
  logic [6:0] sh_q;
  logic [7:0] op_q, lastb_q, ptr_q;
  localparam int PAGE_W = sfw_pkg::PAGE_BYTES;
  logic [23:0] adr_q;
  logic [PAGE_W-1:0] vld_q;
  logic [7:0] pbuf [PAGE_W];

  // Link clock stops between frames, so select high rearms the counters
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) first_q <= 1'b1;
    else first_q <= 1'b0;
  end

  wire [2:0] bit0 = first_q ? 3'h0 : bit_q;
  wire [2:0] nb0 = first_q ? 3'h0 : nb_q;
  wire byte_done = bit0 == 3'h7;
  wire [7:0] byte_in = {sh_q, si};
  wire [2:0] nb_nx = (byte_done && nb0 != sfw_pkg::NB_SAT) ?
                     nb0 + 3'h1 : nb0;
  wire wr_buf = byte_done && nb0 >= sfw_pkg::NB_ADDR && !bsy2_q &&
                op_q == sfw_pkg::OP_PAGE_WR;

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      bit_q <= 3'h0;
      nb_q <= 3'h0;
      sh_q <= 7'h00;
      tog_q <= 1'b0;
      op_q <= 8'h00;
      lastb_q <= 8'h00;
      adr_q <= 24'h000000;
      ptr_q <= 8'h00;
      bsy1_q <= 1'b0;
      bsy2_q <= 1'b0;
    end else begin
      bsy1_q <= op_active_flag;
      bsy2_q <= bsy1_q;
      bit_q <= bit0 + 3'h1;
      nb_q <= nb_nx;
      sh_q <= {sh_q[5:0], si};
      if (first_q) tog_q <= ~tog_q;
      if (byte_done) lastb_q <= byte_in;
      if (byte_done && nb0 == 3'h0) op_q <= byte_in;
      if (byte_done && nb0 != 3'h0 && nb0 < sfw_pkg::NB_ADDR)
        adr_q <= {adr_q[15:0], byte_in};
      if (byte_done && nb0 == 3'h3) ptr_q <= byte_in;
      else if (wr_buf) ptr_q <= ptr_q + 8'h01;
    end
  end

  // Only received bytes are marked for programming
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) vld_q <= '0;
    else if (first_q) vld_q <= '0;
    else if (wr_buf) vld_q[ptr_q] <= 1'b1;
  end

  always_ff @(posedge sclk) begin
    if (wr_buf) pbuf[ptr_q] <= byte_in;
  end

  // ----------------------------------------
  // Crossing into the system clock
  // ----------------------------------------
  // Frame registers are quasi-static once select is high and synchronised
  logic cs1_q, cs2_q, cs3_q, t1_q, t2_q, seen_q;
  logic [4:0] bp1_q, bp2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs1_q <= 1'b1;
      cs2_q <= 1'b1;
      cs3_q <= 1'b1;
      t1_q <= 1'b0;
      t2_q <= 1'b0;
      seen_q <= 1'b0;
      bp1_q <= 5'h00;
      bp2_q <= 5'h00;
    end else begin
      cs1_q <= cs_n;
      cs2_q <= cs1_q;
      cs3_q <= cs2_q;
      t1_q <= tog_q;
      t2_q <= t1_q;
      bp1_q <= protect_range_bits;
      bp2_q <= bp1_q;
      if (cs2_q && !cs3_q) seen_q <= t2_q;
    end
  end

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  wire end_ev = cs2_q && !cs3_q && (t2_q != seen_q);
  wire aligned = bit_q == 3'h0;
  wire is_pe = op_q == sfw_pkg::OP_PAGE_CLR;
  wire is_se = op_q == sfw_pkg::OP_SMALL_CLR;
  wire is_hb = op_q == sfw_pkg::OP_HALF_CLR;
  wire is_be = op_q == sfw_pkg::OP_REGION_CLR;
  wire is_ce = op_q == sfw_pkg::OP_ALL_CLR_A ||
               op_q == sfw_pkg::OP_ALL_CLR_B;
  wire is_pp = op_q == sfw_pkg::OP_PAGE_WR;
  wire is_op1 = aligned && nb_q == sfw_pkg::NB_OP;
  wire er_ok = aligned && nb_q == sfw_pkg::NB_ADDR &&
               (is_pe || is_se || is_hb || is_be);
  wire ce_ok = is_op1 && is_ce;
  // At least one whole data byte
  wire pp_ok = aligned && nb_q >= sfw_pkg::NB_DATA && is_pp;
  wire wr_ok = aligned && nb_q == sfw_pkg::NB_WRAP &&
               op_q == sfw_pkg::OP_WRAP;
  wire wren_ok = is_op1 && op_q == sfw_pkg::OP_WREN;
  wire wrdi_ok = is_op1 && op_q == sfw_pkg::OP_WRDI;
  wire attempt = is_pe || is_se || is_hb || is_be || is_ce || is_pp;

  // Protection: low three bits size a range, bit 3 picks bottom side
  wire [2:0] bp_n = bp2_q[2:0];
  wire [6:0] bp_cnt = (bp_n == 3'h0) ? 7'h00 : 7'(7'h01 << (bp_n - 3'h1));
  wire [6:0] blk = {2'b00, adr_q[sfw_pkg::BLK_LSB +: 5]};
  wire prot = (bp_n != 3'h0) &&
              (bp2_q[3] ? (blk < bp_cnt) : (blk + bp_cnt >= sfw_pkg::NUM_BLK));
  // Chip clear needs every protect bit clear
  wire ce_go = ce_ok && bp2_q == 5'h00;
  wire tgt_go = (er_ok || pp_ok) && !prot;
  // Write latch gates every array command
  wire start = end_ev && !op_active_flag && write_latch_flag &&
               (tgt_go || ce_go);

  sfw_pkg::sfw_kind_e kind_w;
  assign kind_w = is_pe ? sfw_pkg::K_PAGE : is_se ? sfw_pkg::K_SECT :
                  is_hb ? sfw_pkg::K_HALF : is_be ? sfw_pkg::K_BLK :
                  is_ce ? sfw_pkg::K_CHIP : sfw_pkg::K_PROG;
  wire [23:0] msk_w = is_se ? sfw_pkg::MSK_SECT : is_hb ? sfw_pkg::MSK_HALF :
                      is_be ? sfw_pkg::MSK_BLK :
                      is_ce ? sfw_pkg::MSK_CHIP : sfw_pkg::MSK_PAGE;

  // ----------------------------------------
  // Array sequencer
  // ----------------------------------------
  sfw_pkg::sfw_state_e st_q;
  logic [7:0] idx_q;
  logic [23:0] tmr_q;
  logic [2:0] wrap_q;

  // Disable bit high means linear reads
  // Wrap outputs steer every later quad read
  assign wrap_active = !wrap_q[0];
  assign wrap_len_sel = wrap_q[2:1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= sfw_pkg::S_IDLE;
      idx_q <= 8'h00;
      tmr_q <= 24'h000000;
      wrap_q <= sfw_pkg::WRAP_RST;
      write_latch_flag <= 1'b0;
      op_active_flag <= 1'b0;
      arr_erase <= 1'b0;
      arr_kind <= sfw_pkg::K_PAGE;
      arr_addr <= 24'h000000;
      arr_we <= 1'b0;
      arr_wdata <= 8'h00;
      cmd_reject <= 1'b0;
    end else begin
      arr_erase <= 1'b0;
      arr_we <= 1'b0;
      cmd_reject <= end_ev && attempt && !start;
      // Wrap field taken from the final byte
      if (end_ev && wr_ok)
        wrap_q <= lastb_q[sfw_pkg::WRAP_LSB +: 3];
      if (end_ev && wren_ok && !op_active_flag) write_latch_flag <= 1'b1;
      if (end_ev && wrdi_ok && !op_active_flag) write_latch_flag <= 1'b0;
      case (st_q)
        sfw_pkg::S_IDLE: begin
          // Cycle starts, latch cleared well before the end
          if (start) begin
            op_active_flag <= 1'b1;
            write_latch_flag <= 1'b0;
            arr_kind <= kind_w;
            if (is_pp) begin
              st_q <= sfw_pkg::S_WALK;
              idx_q <= 8'h00;
            end else begin
              arr_erase <= 1'b1;
              arr_addr <= adr_q & msk_w;
              tmr_q <= 24'(ERASE_CYC);
              st_q <= sfw_pkg::S_TIME;
            end
          end
        end
        sfw_pkg::S_WALK: begin
          // Each marked byte written inside its page
          arr_we <= vld_q[idx_q];
          arr_addr <= {adr_q[23:8], idx_q};
          arr_wdata <= pbuf[idx_q];
          idx_q <= idx_q + 8'h01;
          if (idx_q == 8'hFF) begin
            tmr_q <= 24'(PROG_CYC);
            st_q <= sfw_pkg::S_TIME;
          end
        end
        sfw_pkg::S_TIME: begin
          tmr_q <= tmr_q - 24'h000001;
          if (tmr_q == 24'h000001) begin
            op_active_flag <= 1'b0;
            st_q <= sfw_pkg::S_IDLE;
          end
        end
        default: st_q <= sfw_pkg::S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_prog_go;
    start && is_pp;
  endsequence
  sequence s_walking;
    op_active_flag && st_q == sfw_pkg::S_WALK;
  endsequence

  chk_wel_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    end_ev && wren_ok && !op_active_flag |=> write_latch_flag)
    else $error("write enable did not set latch");
  chk_erase_wel: assert property (
    @(posedge clk) disable iff (!rst_n)
    arr_erase |-> $past(write_latch_flag) && !write_latch_flag)
    else $error("erase started without latch");
  chk_erase_frame: assert property (
    @(posedge clk) disable iff (!rst_n)
    arr_erase |-> $past(er_ok || ce_ok))
    else $error("erase from a bad frame");
  chk_chip_prot: assert property (
    @(posedge clk) disable iff (!rst_n)
    arr_erase && arr_kind == sfw_pkg::K_CHIP |-> $past(bp2_q) == 5'h00)
    else $error("chip clear under protection");
  chk_area_prot: assert property (
    @(posedge clk) disable iff (!rst_n)
    arr_erase && arr_kind != sfw_pkg::K_CHIP |-> !$past(prot))
    else $error("protected area erased");
  chk_busy_block: assert property (
    @(posedge clk) disable iff (!rst_n)
    op_active_flag && end_ev |=> !arr_erase &&
    (st_q != sfw_pkg::S_WALK || $past(st_q) == sfw_pkg::S_WALK))
    else $error("command taken while busy");
  chk_prog_walk: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_prog_go |=> s_walking [*8])
    else $error("program walk did not run");
  chk_page_bound: assert property (
    @(posedge clk) disable iff (!rst_n)
    arr_we |-> arr_addr[23:8] == adr_q[23:8] && $past(vld_q[idx_q]))
    else $error("write left the page");
  chk_wrap_take: assert property (
    @(posedge clk) disable iff (!rst_n)
    end_ev && wr_ok |=> wrap_q == $past(lastb_q[6:4]))
    else $error("wrap field not latched");
  chk_busy_start: assert property (
    @(posedge clk) disable iff (!rst_n)
    start |=> op_active_flag && !write_latch_flag)
    else $error("cycle did not start");
endmodule

// [bench/sfw_host.sv]
`timescale 1ns/1ps
module sfw_host (
  output logic sclk,
  output logic cs_n,
  output logic si
);
  logic [7:0] fq[$];

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  task automatic push(input logic [7:0] b);
    fq.push_back(b);
  endtask

  task automatic bit_out(input logic v);
    si = v;
    #15;
    sclk = 1'b1;
    #15;
    sclk = 1'b0;
  endtask

  // ----------------------------------------
  // Frame: whole bytes MSB first, stray bits
  // ----------------------------------------
  // select held low
  task automatic send(input int extra);
    logic [7:0] b;
    cs_n = 1'b0;
    #20;
    while (fq.size() > 0) begin
      b = fq.pop_front();
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
    end
    for (int i = 0; i < extra; i++) bit_out(1'b1);
    #20;
    cs_n = 1'b1;
    // Released line must not keep the last bit
    si = ~si;
    #200;
  endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  localparam int EC = 20;
  logic clk, arst_n, sclk, cs_n, si;
  logic [4:0] protect_range_bits;
  logic write_latch_flag, op_active_flag, wrap_active;
  logic arr_erase, arr_we, cmd_reject, er_busy;
  logic [1:0] wrap_len_sel;
  sfw_pkg::sfw_kind_e arr_kind, er_kind;
  logic [23:0] arr_addr, er_addr;
  logic [15:0] pg_hi;
  logic [7:0] arr_wdata;
  logic [7:0] pg [0:255];
  int failures, cmp_count, er_cnt, we_cnt, rej_cnt, busy_cyc;
  logic [7:0] ops [6] = '{8'h81, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
  logic [23:0] msks [6] = '{sfw_pkg::MSK_PAGE, sfw_pkg::MSK_SECT,
    sfw_pkg::MSK_HALF, sfw_pkg::MSK_BLK, sfw_pkg::MSK_CHIP, sfw_pkg::MSK_CHIP};
  sfw_pkg::sfw_kind_e kinds [6] = '{sfw_pkg::K_PAGE, sfw_pkg::K_SECT,
    sfw_pkg::K_HALF, sfw_pkg::K_BLK, sfw_pkg::K_CHIP, sfw_pkg::K_CHIP};

  sfw_core #(.ERASE_CYC(EC), .PROG_CYC(10)) i_dut (.clk(clk),
    .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .si(si),
    .protect_range_bits(protect_range_bits),
    .write_latch_flag(write_latch_flag), .op_active_flag(op_active_flag),
    .wrap_active(wrap_active), .wrap_len_sel(wrap_len_sel),
    .arr_erase(arr_erase), .arr_kind(arr_kind), .arr_addr(arr_addr),
    .arr_we(arr_we), .arr_wdata(arr_wdata), .cmd_reject(cmd_reject));
  sfw_host i_host (.sclk(sclk), .cs_n(cs_n), .si(si));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Array side monitor
  // ----------------------------------------
  // Mid-cycle sampling keeps clear of the launching edge
  always @(negedge clk) begin
    if (op_active_flag === 1'b1) busy_cyc++;
    if (cmd_reject === 1'b1) rej_cnt++;
    if (arr_erase === 1'b1) begin
      er_cnt++;
      er_kind = arr_kind;
      er_addr = arr_addr;
      er_busy = op_active_flag;
    end
    if (arr_we === 1'b1) begin
      we_cnt++;
      pg[arr_addr[7:0]] = arr_wdata;
      pg_hi = arr_addr[23:8];
    end
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_v(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_c(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      failures++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int na);
    i_host.push(op);
    for (int i = 0; i < na; i++) i_host.push(a[23-8*i -: 8]);
  endtask

  // Next frame only once the array cycle is over
  task automatic go(input int extra);
    int n;
    i_host.send(extra);
    n = 0;
    while (op_active_flag !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic wren();
    hdr(sfw_pkg::OP_WREN, 24'h000000, 0);
    go(0);
  endtask

  task automatic rej_case(input logic [7:0] op, input logic [23:0] a,
    input int na, input int nd, input int extra, input bit wr);
    int r0, e0;
    r0 = rej_cnt;
    e0 = er_cnt + we_cnt;
    if (wr) wren();
    hdr(op, a, na);
    for (int i = 0; i < nd; i++) i_host.push(8'h3C);
    go(extra);
    chk_c(rej_cnt - r0, 1);
    chk_c(er_cnt + we_cnt - e0, 0);
  endtask

  initial begin
    #400000;
    failures++;
    wrap_up();
  end

  initial begin
    arst_n = 1'b0;
    protect_range_bits = 5'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk_v(wrap_active, 24'h0);
    chk_v(write_latch_flag, 24'h0);
    for (int l = 0; l < 4; l++) begin
      hdr(sfw_pkg::OP_WRAP, 24'hABCDEF, 3);
      i_host.push({1'b0, l[1:0], 5'h00});
      go(0);
      chk_v(wrap_active, 24'h1);
      chk_v(wrap_len_sel, 24'(l));
    end
    hdr(sfw_pkg::OP_WRAP, 24'h000000, 3);
    i_host.push(8'h50);
    go(0);
    chk_v(wrap_active, 24'h0);
    rej_case(sfw_pkg::OP_SMALL_CLR, 24'h0A5678, 3, 0, 0, 0);
    for (int k = 0; k < 6; k++) begin
      wren();
      chk_v(write_latch_flag, 24'h1);
      er_cnt = 0;
      busy_cyc = 0;
      hdr(ops[k], 24'h0A5678, (k < 4) ? 3 : 0);
      go(0);
      chk_c(er_cnt, 1);
      chk_v(er_kind, kinds[k]);
      chk_v(er_addr, 24'h0A5678 & msks[k]);
      chk_v(er_busy, 24'h1);
      chk_v(write_latch_flag, 24'h0);
      chk_c(int'(busy_cyc >= EC && busy_cyc <= EC + 2), 1);
    end
    rej_case(sfw_pkg::OP_REGION_CLR, 24'h0A5678, 3, 0, 4, 1);
    rej_case(sfw_pkg::OP_HALF_CLR, 24'h0A5678, 2, 0, 0, 1);
    rej_case(sfw_pkg::OP_ALL_CLR_A, 24'h000000, 0, 0, 3, 1);
    rej_case(sfw_pkg::OP_PAGE_WR, 24'h012300, 3, 1, 5, 1);
    @(posedge clk);
    protect_range_bits <= 5'h01;
    repeat (4) @(posedge clk);
    rej_case(sfw_pkg::OP_REGION_CLR, 24'h1F1234, 3, 0, 0, 1);
    rej_case(sfw_pkg::OP_ALL_CLR_B, 24'h000000, 0, 0, 0, 1);
    rej_case(sfw_pkg::OP_PAGE_WR, 24'h1FFF00, 3, 1, 0, 1);
    @(posedge clk);
    protect_range_bits <= 5'h0A;
    repeat (4) @(posedge clk);
    rej_case(sfw_pkg::OP_SMALL_CLR, 24'h010000, 3, 0, 0, 1);
    wren();
    er_cnt = 0;
    hdr(sfw_pkg::OP_REGION_CLR, 24'h1F0000, 3);
    go(0);
    chk_c(er_cnt, 1);
    @(posedge clk);
    protect_range_bits <= 5'h14;
    repeat (4) @(posedge clk);
    rej_case(sfw_pkg::OP_HALF_CLR, 24'h1A8000, 3, 0, 0, 1);
    @(posedge clk);
    protect_range_bits <= 5'h00;
    repeat (4) @(posedge clk);
    wren();
    hdr(sfw_pkg::OP_PAGE_WR, 24'h012340, 3);
    i_host.push(8'h5A);
    i_host.send(0);
    er_cnt = 0;
    rej_cnt = 0;
    hdr(sfw_pkg::OP_ALL_CLR_A, 24'h000000, 0);
    go(0);
    chk_c(rej_cnt, 1);
    chk_c(er_cnt, 0);
    wren();
    we_cnt = 0;
    hdr(sfw_pkg::OP_PAGE_WR, 24'h0123FE, 3);
    i_host.push(8'hAA);
    i_host.push(8'hBB);
    i_host.push(8'hCC);
    go(0);
    chk_c(we_cnt, 3);
    chk_v(pg[8'hFE], 24'hAA);
    chk_v(pg[8'h00], 24'hCC);
    chk_v(pg_hi, 24'h0123);
    wren();
    we_cnt = 0;
    hdr(sfw_pkg::OP_PAGE_WR, 24'h012300, 3);
    for (int i = 0; i < 258; i++) i_host.push((i < 256) ? 8'h11 : 8'hEE);
    go(0);
    chk_c(we_cnt, 256);
    chk_v(pg[8'h01], 24'hEE);
    chk_v(pg[8'h02], 24'h11);
    wrap_up();
  end
endmodule
